/* inc/sec_pkg.sv */
package sec_pkg;

  // Opcodes
  localparam logic [7:0] OP_STATUS_STORE = 8'h01;
  localparam logic [7:0] OP_ARRAY_STORE = 8'h02;
  localparam logic [7:0] OP_ARRAY_FETCH = 8'h03;
  localparam logic [7:0] OP_CLEAR_WRITE_LATCH = 8'h04;
  localparam logic [7:0] OP_STATUS_FETCH = 8'h05;
  localparam logic [7:0] OP_SET_WRITE_LATCH = 8'h06;
  localparam logic [7:0] OP_UNIQUE_SERIAL_FETCH = 8'h81;
  localparam logic [7:0] OP_ID_PAGE_STORE = 8'h82;
  localparam logic [7:0] OP_ID_PAGE_FETCH = 8'h83;

  // Status layout
  localparam int unsigned STAT_W = 8;
  localparam int unsigned STAT_PROTECT_BIT = 7;
  localparam int unsigned STAT_BP_HI_BIT = 3;
  localparam int unsigned STAT_BP_LO_BIT = 2;
  localparam int unsigned STAT_LATCH_BIT = 1;
  localparam int unsigned STAT_BUSY_BIT = 0;
  localparam logic [2:0] STAT_RESERVED_VAL = 3'h0;
  localparam logic [1:0] BP_RESET = 2'h0;
  localparam logic PROTECT_RESET = 1'b0;

  // Block protect encodings
  localparam logic [1:0] BP_NONE = 2'h0;
  localparam logic [1:0] BP_QUARTER = 2'h1;
  localparam logic [1:0] BP_HALF = 2'h2;
  localparam logic [1:0] BP_WHOLE = 2'h3;

  // Array address
  localparam int unsigned ADDR_W = 13;
  localparam int unsigned ADDR_HI_W = 5;
  localparam logic [1:0] QUARTER_TOP = 2'h3;

  // Self-timed write cycle
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned WRITE_CYCLE_NS = 3000000;
  localparam int unsigned WRITE_CYCLE_CLKS = WRITE_CYCLE_NS / CLK_PERIOD_NS;

  // Synchroniser depth
  localparam int unsigned SYNC_STAGES = 3;

  typedef enum logic [2:0] {
    ST_OPCODE = 3'h0,
    ST_ADDR = 3'h1,
    ST_STREAM = 3'h3,
    ST_DATA = 3'h2,
    ST_WAIT = 3'h6
  } sec_state_t;

  typedef enum logic [1:0] {
    ACT_NONE = 2'h0,
    ACT_SET = 2'h1,
    ACT_CLEAR = 2'h2,
    ACT_STORE = 2'h3
  } sec_action_t;

endpackage

/* sim/sec_asserts.sv */
`timescale 1ns/100ps
module sec_asserts #(
  parameter int unsigned WRITE_CYCLE_COUNT = 600
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe,
  input wire logic wp_n,
  input wire logic [12:0] arr_addr,
  input wire logic arr_rd,
  input wire logic [7:0] arr_rdata,
  input wire logic [12:0] chk_addr,
  input wire logic chk_array_locked,
  input wire logic chk_id_locked,
  input wire logic [7:0] status_value,
  input wire logic hw_locked
);
  logic [17:0] busy_cnt_q;
  logic [17:0] busy_cnt_d;
  logic exp_lock;
  assign busy_cnt_d = status_value[0] ? busy_cnt_q + 18'h1 : 18'h0;
  assign exp_lock = (status_value[3:2] == 2'h3) || (status_value[3:2] == 2'h2 && chk_addr[12])
    || (status_value[3:2] == 2'h1 && chk_addr[12:11] == 2'h3);
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      busy_cnt_q <= '0;
    end else begin
      busy_cnt_q <= busy_cnt_d;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  AST_RSV_ZERO: assert property (status_value[6:4] == 3'h0)
    else $error("reserved status bits not zero");
  AST_HW_ON: assert property ((!wp_n)[*6] ##0 status_value[7] |-> hw_locked)
    else $error("hardware protection not entered");
  AST_HW_OFF: assert property (wp_n[*6] |-> !hw_locked)
    else $error("hardware protection not left with pin high");
  AST_ID_LOCK: assert property ($stable(status_value[3:2])
    |-> chk_id_locked == (status_value[3:2] == 2'h3))
    else $error("id page lock wrong");
  AST_LOCK_RANGE: assert property ($stable(chk_addr) && $stable(status_value[3:2])
    |-> chk_array_locked == exp_lock)
    else $error("protected range wrong");
  AST_BUSY_LEN: assert property ($fell(status_value[0])
    |-> busy_cnt_q >= WRITE_CYCLE_COUNT && busy_cnt_q <= WRITE_CYCLE_COUNT + 1)
    else $error("write cycle length wrong");
  AST_WEL_END: assert property ($fell(status_value[0]) |-> !status_value[1])
    else $error("latch not cleared at cycle end");
  AST_NV_STEADY: assert property (!$fell(status_value[0])
    |-> $stable({status_value[7], status_value[3:2]}))
    else $error("protect bits changed outside cycle end");
  AST_BUSY_WEL: assert property ($rose(status_value[0]) |-> status_value[1])
    else $error("write cycle started without latch");
  AST_OE_DESEL: assert property (cs_n |-> !miso_oe)
    else $error("data out driven while deselected");
  AST_ARR_IDLE: assert property (status_value[0] |-> !arr_rd)
    else $error("array read during write cycle");
endmodule
bind sec_core sec_asserts #(.WRITE_CYCLE_COUNT(WRITE_CYCLE_COUNT)) asserts_u (
  .clock(clock), .rstn(rstn), .sck(sck), .cs_n(cs_n), .mosi(mosi), .miso(miso),
  .miso_oe(miso_oe), .wp_n(wp_n), .arr_addr(arr_addr), .arr_rd(arr_rd),
  .arr_rdata(arr_rdata), .chk_addr(chk_addr), .chk_array_locked(chk_array_locked),
  .chk_id_locked(chk_id_locked), .status_value(status_value), .hw_locked(hw_locked)
);

/* sim/sec_core_tb_top.sv */
`timescale 1ns/100ps
`define CHK(nm, ex, got) \
  begin \
    num_checks++; \
    if ((got) !== (ex)) begin \
      err_count++; \
      $display("CHECK FAILED %s exp %h got %h", nm, ex, got); \
    end \
  end
module sec_core_tb_top;
  import sec_pkg::*;
  logic clock, rstn, sck, cs_n, mosi, miso, miso_oe, wp_n, arr_rd;
  logic chk_array_locked, chk_id_locked, hw_locked;
  logic [12:0] arr_addr, chk_addr;
  logic [7:0] arr_rdata, status_value;
  logic [47:0] rx_w;
  int err_count = 0;
  int num_checks = 0;
  logic [7:0] bad_ops [5] = '{8'hab, OP_ARRAY_STORE, OP_UNIQUE_SERIAL_FETCH,
    OP_ID_PAGE_STORE, OP_ID_PAGE_FETCH};
  logic [12:0] probe [5] = '{13'h0000, 13'h0fff, 13'h1000, 13'h17ff, 13'h1800};
  function automatic logic [7:0] mem_byte(logic [12:0] a);
    return a[7:0] ^ {3'h0, a[12:8]};
  endfunction
  // Memory answers at once, as the core expects
  assign arr_rdata = mem_byte(arr_addr);
  sec_core #(.WRITE_CYCLE_COUNT(600)) dut_u (.clock(clock), .rstn(rstn), .sck(sck),
    .cs_n(cs_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe), .wp_n(wp_n),
    .arr_addr(arr_addr), .arr_rd(arr_rd), .arr_rdata(arr_rdata), .chk_addr(chk_addr),
    .chk_array_locked(chk_array_locked), .chk_id_locked(chk_id_locked),
    .status_value(status_value), .hw_locked(hw_locked));
  sec_host_model host_u (.sck(sck), .cs_n(cs_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe));
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  task close_out;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task cyc(int n);
    repeat (n) @(posedge clock);
  endtask
  task cmd(logic [7:0] op);
    host_u.xfer({40'h0, op}, 8, rx_w);
  endtask
  task sfetch(logic [7:0] ex);
    host_u.xfer({24'h0, OP_STATUS_FETCH, 16'h0}, 24, rx_w);
    `CHK("status fetch", {8'hzz, ex, ex}, rx_w[23:0])
  endtask
  task store(logic [7:0] d);
    cmd(OP_SET_WRITE_LATCH);
    host_u.xfer({32'h0, OP_STATUS_STORE, d}, 16, rx_w);
  endtask
  // Bounded wait for the write cycle to finish
  task wait_idle;
    int k;
    for (k = 0; k < 1000 && status_value[0] !== 1'b0; k++) begin
      @(posedge clock);
    end
    if (k == 1000) begin
      err_count++;
      close_out;
    end
  endtask
  task tdone(string s);
    $display("test %s done", s);
  endtask
  initial begin
    rstn = 1'b0;
    wp_n = 1'b1;
    chk_addr = '0;
    cyc(10);
    rstn <= 1'b1;
    cyc(6);
    `CHK("reset status", 8'h00, status_value)
    sfetch(8'h00);
    cmd(OP_SET_WRITE_LATCH);
    sfetch(8'h02);
    cmd(OP_CLEAR_WRITE_LATCH);
    sfetch(8'h00);
    tdone("latch");
    cmd(OP_SET_WRITE_LATCH);
    host_u.xfer({31'h0, OP_STATUS_STORE, 8'h8c, 1'b0}, 17, rx_w);
    `CHK("late deselect", 8'h02, status_value)
    store(8'hff);
    sfetch(8'h03);
    host_u.xfer({16'h0, OP_ARRAY_FETCH, 16'h0010, 8'h0}, 32, rx_w);
    `CHK("read while busy", 8'hzz, rx_w[7:0])
    wait_idle;
    `CHK("stored status", 8'h8c, status_value)
    tdone("store");
    cyc(1);
    wp_n <= 1'b0;
    cyc(6);
    `CHK("hw lock on", 1'b1, hw_locked)
    store(8'h00);
    wait_idle;
    `CHK("refused store", 8'h8e, status_value)
    cyc(1);
    wp_n <= 1'b1;
    cyc(6);
    `CHK("hw lock off", 1'b0, hw_locked)
    tdone("protect");
    for (int bp = 0; bp < 4; bp++) begin
      store({1'b0, 3'h7, bp[1:0], 2'h3});
      wait_idle;
      `CHK("bp status", {6'h0, bp[1:0]} << 2, status_value)
      for (int a = 0; a < 5; a++) begin
        cyc(1);
        chk_addr <= probe[a];
        cyc(3);
        `CHK("array lock", bp == 3 || (bp == 2 && probe[a] >= 13'h1000)
          || (bp == 1 && probe[a] >= 13'h1800), chk_array_locked)
        `CHK("id lock", bp == 3, chk_id_locked)
      end
    end
    tdone("blocks");
    host_u.xfer({OP_ARRAY_FETCH, 16'hffff, 24'h0}, 48, rx_w);
    `CHK("array read", {mem_byte(13'h1fff), mem_byte(13'h0), mem_byte(13'h1)},
      rx_w[23:0])
    for (int i = 0; i < 5; i++) begin
      host_u.xfer({24'h0, bad_ops[i], 16'h0}, 24, rx_w);
      `CHK("refused opcode", 16'hzzzz, rx_w[15:0])
    end
    `CHK("status kept", 8'h0c, status_value)
    host_u.xfer({36'h0, OP_STATUS_FETCH, 4'h0}, 12, rx_w);
    `CHK("partial status", 4'h0, rx_w[3:0])
    `CHK("released out", 1'b0, miso_oe)
    sfetch(8'h0c);
    tdone("stream");
    host_u.set_mode(1'b1);
    sfetch(8'h0c);
    host_u.xfer({16'h0, OP_ARRAY_FETCH, 16'h0123, 8'h0}, 32, rx_w);
    `CHK("mode 3 read", mem_byte(13'h0123), rx_w[7:0])
    host_u.set_mode(1'b0);
    tdone("mode3");
    cmd(OP_SET_WRITE_LATCH);
    `CHK("latch before reset", 8'h0e, status_value)
    cyc(1);
    rstn <= 1'b0;
    cyc(2);
    rstn <= 1'b1;
    cyc(6);
    `CHK("latch after reset", 8'h00, status_value)
    sfetch(8'h00);
    tdone("reset");
    close_out;
  end
endmodule

/* sim/sec_host_model.sv */
`timescale 1ns/100ps
module sec_host_model (
  output logic sck,
  output logic cs_n,
  output logic mosi,
  input wire logic miso,
  input wire logic miso_oe
);
  logic idle_lvl;
  initial begin
    idle_lvl = 1'b0;
    sck = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  // Mode 0 parks the clock low, mode 3 high; it stands still between frames
  task automatic set_mode(input logic m);
    idle_lvl = m;
    #40 sck = m;
  endtask
  task automatic xfer(input logic [47:0] tx, input int n, output logic [47:0] rx);
    rx = '0;
    #37 cs_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      #80 sck = 1'b0;
      mosi = tx[i];
      #80 sck = 1'b1;
      rx[i] = miso_oe ? miso : 1'bz;
    end
    // Mode 3 ends on the last rising edge, so no extra falling edge there
    #80 sck = idle_lvl;
    #20 cs_n = 1'b1;
    mosi = ~mosi;
    #200;
  endtask
endmodule

/* verilog/sec_core.sv */
`timescale 1ns/100ps
module sec_core #(
  parameter int unsigned WRITE_CYCLE_COUNT = sec_pkg::WRITE_CYCLE_CLKS
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe,
  input wire logic wp_n,
  output logic [sec_pkg::ADDR_W-1:0] arr_addr,
  output logic arr_rd,
  input wire logic [7:0] arr_rdata,
  input wire logic [sec_pkg::ADDR_W-1:0] chk_addr,
  output logic chk_array_locked,
  output logic chk_id_locked,
  output logic [sec_pkg::STAT_W-1:0] status_value,
  output logic hw_locked
);
  import sec_pkg::*;

  localparam int unsigned CNT_W = $clog2(WRITE_CYCLE_COUNT + 1);
  localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(WRITE_CYCLE_COUNT - 1);
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
  localparam logic [2:0] LAST_BIT = 3'h7;

  // ---------------- Link side, clocked by the serial clock ----------------

  // Deselect clears the frame logic without needing a clock edge
  logic link_clr_n;
  assign link_clr_n = rstn & ~cs_n;

  sec_state_t state_q;
  sec_state_t state_d;
  logic [2:0] bit_cnt_q;
  logic [7:0] sr_q;
  logic [ADDR_W-1:0] addr_q;
  logic [ADDR_W-1:0] addr_d;
  logic [ADDR_HI_W-1:0] hi_q;
  logic [ADDR_HI_W-1:0] hi_d;
  logic hi_sel_q;
  logic hi_sel_d;
  logic [7:0] stat_hold_q;
  logic [7:0] stat_hold_d;
  logic is_stat_q;
  logic is_stat_d;

  // Frame results that must outlive the frame are not cleared by deselect
  sec_action_t act_q;
  sec_action_t act_d;
  logic [7:0] store_data_q;
  logic [7:0] store_data_d;

  logic [STAT_W-1:0] status_lk;
  logic busy_lk;
  logic latch_lk;
  logic [7:0] sr_next;
  logic byte_done;

  assign sr_next = {sr_q[6:0], mosi};
  assign byte_done = (bit_cnt_q == LAST_BIT);
  assign busy_lk = status_lk[STAT_BUSY_BIT];
  assign latch_lk = status_lk[STAT_LATCH_BIT];

  // Status copy for the link side; it only moves while the serial clock runs
  sec_sync #(
    .WIDTH(STAT_W),
    .RESET_VAL('0)
  ) u_stat_sync (
    .clock(sck),
    .rstn(rstn),
    .d(status_value),
    .q(status_lk)
  );

  always_comb begin
    state_d = state_q;
    addr_d = addr_q;
    hi_d = hi_q;
    hi_sel_d = hi_sel_q;
    stat_hold_d = stat_hold_q;
    is_stat_d = is_stat_q;
    act_d = act_q;
    store_data_d = store_data_q;
    case (state_q)
      ST_OPCODE: begin
        // Any edge of a new frame drops what the last frame left
        act_d = ACT_NONE;
        if (byte_done) begin
          case (sr_next)
            OP_STATUS_FETCH: begin
              state_d = ST_STREAM;
              is_stat_d = 1'b1;
              stat_hold_d = status_lk;
            end
            OP_SET_WRITE_LATCH: begin
              state_d = ST_WAIT;
              if (!busy_lk) begin
                act_d = ACT_SET;
              end
            end
            OP_CLEAR_WRITE_LATCH: begin
              state_d = ST_WAIT;
              if (!busy_lk) begin
                act_d = ACT_CLEAR;
              end
            end
            OP_STATUS_STORE: begin
              state_d = (!busy_lk && latch_lk) ? ST_DATA : ST_WAIT;
            end
            OP_ARRAY_FETCH: begin
              state_d = busy_lk ? ST_WAIT : ST_ADDR;
              is_stat_d = 1'b0;
            end
            OP_ARRAY_STORE, OP_ID_PAGE_FETCH, OP_ID_PAGE_STORE,
            OP_UNIQUE_SERIAL_FETCH: begin
              // Served by neighbouring blocks; this decoder only idles
              state_d = ST_WAIT;
            end
            default: begin
              state_d = ST_WAIT;
            end
          endcase
        end
      end
      ST_ADDR: begin
        if (byte_done) begin
          if (!hi_sel_q) begin
            hi_d = sr_next[ADDR_HI_W-1:0];
            hi_sel_d = 1'b1;
          end else begin
            addr_d = {hi_q, sr_next};
            state_d = ST_STREAM;
          end
        end
      end
      ST_STREAM: begin
        if (byte_done) begin
          if (is_stat_q) begin
            stat_hold_d = status_lk;
          end else begin
            addr_d = addr_q + ADDR_W'(1);
          end
        end
      end
      ST_DATA: begin
        if (byte_done) begin
          store_data_d = sr_next;
          act_d = ACT_STORE;
          state_d = ST_WAIT;
        end
      end
      ST_WAIT: begin
        // A clock edge past the data byte cancels the status write
        if (act_q == ACT_STORE) begin
          act_d = ACT_NONE;
        end
      end
      default: begin
        state_d = ST_WAIT;
      end
    endcase
  end

  always_ff @(posedge sck or negedge link_clr_n) begin
    if (!link_clr_n) begin
      state_q <= ST_OPCODE;
      bit_cnt_q <= 3'h0;
      sr_q <= 8'h00;
      addr_q <= '0;
      hi_q <= '0;
      hi_sel_q <= 1'b0;
      stat_hold_q <= 8'h00;
      is_stat_q <= 1'b0;
    end else begin
      state_q <= state_d;
      bit_cnt_q <= bit_cnt_q + 3'h1;
      sr_q <= sr_next;
      addr_q <= addr_d;
      hi_q <= hi_d;
      hi_sel_q <= hi_sel_d;
      stat_hold_q <= stat_hold_d;
      is_stat_q <= is_stat_d;
    end
  end

  always_ff @(posedge sck or negedge rstn) begin
    if (!rstn) begin
      act_q <= ACT_NONE;
      store_data_q <= 8'h00;
    end else begin
      act_q <= act_d;
      store_data_q <= store_data_d;
    end
  end

  // Output shifts on the falling edge, MSB first
  logic stream_on;
  logic [2:0] out_idx;
  logic out_bit;
  assign stream_on = (state_q == ST_STREAM);
  assign out_idx = ~bit_cnt_q;
  assign out_bit = is_stat_q ? stat_hold_q[out_idx] : arr_rdata[out_idx];

  always_ff @(negedge sck or negedge link_clr_n) begin
    if (!link_clr_n) begin
      miso <= 1'b0;
      miso_oe <= 1'b0;
    end else begin
      miso <= out_bit;
      miso_oe <= stream_on;
    end
  end

  assign arr_addr = addr_q;
  assign arr_rd = stream_on & ~is_stat_q;

  // ---------------- Core side, clocked by the system clock ----------------

  logic cs_n_s;
  logic wp_n_s;
  logic [1:0] act_s;
  logic [7:0] data_s;

  // Action and data are steady before deselect, since the serial clock has stopped
  sec_sync #(
    .WIDTH(12),
    .RESET_VAL(12'hc00)
  ) u_core_sync (
    .clock(clock),
    .rstn(rstn),
    .d({cs_n, wp_n, act_q, store_data_q}),
    .q({cs_n_s, wp_n_s, act_s, data_s})
  );

  logic cs_prev_q;
  logic latch_q;
  logic latch_d;
  logic busy_q;
  logic busy_d;
  logic protect_q;
  logic protect_d;
  logic [1:0] bp_q;
  logic [1:0] bp_d;
  logic pend_protect_q;
  logic [1:0] pend_bp_q;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;

  logic cs_rise;
  logic cycle_end;
  logic store_ok;
  logic set_ok;
  logic clear_ok;

  assign cs_rise = cs_n_s & ~cs_prev_q;
  assign hw_locked = protect_q & ~wp_n_s;
  assign set_ok = cs_rise && (act_s == ACT_SET) && !busy_q;
  assign clear_ok = cs_rise && (act_s == ACT_CLEAR);
  // Protect bit low, or pin high, leaves the status writable with the latch
  assign store_ok = cs_rise && (act_s == ACT_STORE) && latch_q && !busy_q
                    && !hw_locked;
  assign cycle_end = busy_q && (cnt_q == '0);

  assign busy_d = store_ok ? 1'b1 : (cycle_end ? 1'b0 : busy_q);
  assign cnt_d = store_ok ? CNT_LOAD : ((busy_q && cnt_q != '0) ? cnt_q - CNT_ONE : cnt_q);
  assign latch_d = set_ok ? 1'b1 : ((clear_ok || cycle_end) ? 1'b0 : latch_q);
  assign protect_d = cycle_end ? pend_protect_q : protect_q;
  assign bp_d = cycle_end ? pend_bp_q : bp_q;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cs_prev_q <= 1'b1;
      latch_q <= 1'b0;
      busy_q <= 1'b0;
      cnt_q <= '0;
      protect_q <= PROTECT_RESET;
      bp_q <= BP_RESET;
    end else begin
      cs_prev_q <= cs_n_s;
      latch_q <= latch_d;
      busy_q <= busy_d;
      cnt_q <= cnt_d;
      protect_q <= protect_d;
      bp_q <= bp_d;
    end
  end

  // New values take effect when the timed cycle ends
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pend_protect_q <= PROTECT_RESET;
      pend_bp_q <= BP_RESET;
    end else if (store_ok) begin
      pend_protect_q <= data_s[STAT_PROTECT_BIT];
      pend_bp_q <= {data_s[STAT_BP_HI_BIT], data_s[STAT_BP_LO_BIT]};
    end
  end

  assign status_value = {protect_q, STAT_RESERVED_VAL, bp_q, latch_q, busy_q};

  // Region lookup for the array and ID page writers
  logic top_half;
  logic top_quarter;
  logic array_lock_d;
  assign top_half = chk_addr[ADDR_W-1];
  assign top_quarter = (chk_addr[ADDR_W-1 -: 2] == QUARTER_TOP);
  assign array_lock_d = (bp_q == BP_WHOLE) || ((bp_q == BP_HALF) && top_half)
                        || ((bp_q == BP_QUARTER) && top_quarter);

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      chk_array_locked <= 1'b0;
      chk_id_locked <= 1'b0;
    end else begin
      chk_array_locked <= array_lock_d;
      chk_id_locked <= (bp_q == BP_WHOLE);
    end
  end
endmodule

/* verilog/sec_sync.sv */
`timescale 1ns/100ps
module sec_sync #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  import sec_pkg::*;

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] out_d;

  // A bit moves only once the second and third stage agree
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      assign out_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : q[i];
    end
  endgenerate

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s1_q <= RESET_VAL;
      s2_q <= RESET_VAL;
      s3_q <= RESET_VAL;
      q <= RESET_VAL;
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
      q <= out_d;
    end
  end
endmodule
